// ---- lsw_host_model.sv ----
// Host model that issues record reads and captures the streamed bytes
`timescale 1ns/1ps
module lsw_host_model (
  input wire logic mclk,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [8:0] byte_index,
  input wire logic rd_done,
  output logic rd_start,
  output logic [31:0] cdw11,
  output logic retain_evt,
  output logic rd_ok
);
  logic [7:0] rec [512];
  int n_bytes;
  initial begin
    rd_start = 1'b0;
    cdw11 = 32'h0;
    retain_evt = 1'b0;
    rd_ok = 1'b0;
  end
  // Called only from idle, so a start is never refused
  task automatic read(input logic [3:0] set, input logic ret,
                      input logic ok);
    n_bytes = 0;
    @(posedge mclk);
    rd_start <= 1'b1;
    cdw11 <= {28'h0, set};
    retain_evt <= ret;
    rd_ok <= ok;
    @(posedge mclk);
    rd_start <= 1'b0;
    for (int i = 0; i < 600 && rd_done !== 1'b1; i++) begin
      @(negedge mclk);
      if (byte_valid === 1'b1) begin
        rec[byte_index] = byte_data;
        n_bytes++;
      end
    end
    // Completion status stays put through the done cycle
    @(posedge mclk);
  endtask
endmodule // lsw_host_model

// ---- lsw_log_top.sv ----
// Per-set latency window log record generator
// Function
// [R01] One record per storage set, each streamed as exactly 512 bytes.
// [R02] The set number comes in command doubleword 11 and its record returns.
// [R03] Byte 0 bits 2:0 hold 0 off, 1 deterministic or 2 nondeterministic.
// [R04] Byte 0 bits 7:3 and all of byte 1 read as zero.
// [R05] Bytes 3:2 carry read, write, time warnings in bits 0..2, rest zero.
// [R06] Event flags accumulate independently and may be set together.
// [R07] A successful read with retain clear clears that set's event flags.
// [R08] The same read clears that set's aggregate event entry.
// [R09] Typical, maximum and minimum bytes are fixed worst-case constants.
// [R10] Retain set or a failed read leaves flags and aggregate entry alone.
// [R11] A newly added aggregate entry raises a one-cycle host event.
`timescale 1ns/1ps
module lsw_log_top (
  input wire logic mclk,
  input wire logic srst,
  input wire logic rd_start,
  input wire logic [31:0] cdw11,
  input wire logic retain_evt,
  input wire logic rd_ok,
  input wire logic [lsw_pkg::NUM_SETS*3-1:0] set_window,
  input wire logic [lsw_pkg::NUM_SETS*lsw_pkg::EVT_W-1:0] evt_in,
  output logic rd_busy,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic [8:0] byte_index,
  output logic byte_last,
  output logic rd_done,
  output logic [lsw_pkg::NUM_SETS-1:0] agg_entries,
  output logic async_evt
);
  typedef enum logic [1:0] {
    LSW_IDLE, LSW_SEND, LSW_WAIT
  } lsw_state_t;

  lsw_state_t state_q;
  logic [8:0] idx_q;
  logic [lsw_pkg::SET_W-1:0] sel_q;
  logic retain_q;
  logic [lsw_pkg::NUM_SETS-1:0] clr_vec;
  logic [lsw_pkg::NUM_SETS-1:0] new_vec;
  logic [lsw_pkg::NUM_SETS*3-1:0] win_vec;
  logic [lsw_pkg::NUM_SETS*lsw_pkg::EVT_W-1:0] flag_vec;
  logic [2:0] sel_win;
  logic [lsw_pkg::EVT_W-1:0] sel_flags;
  logic [7:0] byte_d;
  logic async_q;

  for (genvar g = 0; g < lsw_pkg::NUM_SETS; g++) begin : g_set
    lsw_win_sync u_sync (
      .mclk(mclk),
      .srst(srst),
      .win_in(set_window[g*3 +: 3]),
      .win_q(win_vec[g*3 +: 3])
    );
    lsw_set_flags u_flags (
      .mclk(mclk),
      .srst(srst),
      .evt_set(evt_in[g*lsw_pkg::EVT_W +: lsw_pkg::EVT_W]),
      .clr(clr_vec[g]),
      .flags_q(flag_vec[g*lsw_pkg::EVT_W +: lsw_pkg::EVT_W]),
      .agg_q(agg_entries[g]),
      .agg_new(new_vec[g])
    );
  end

  assign sel_win = win_vec[sel_q*3 +: 3];
  assign sel_flags = flag_vec[sel_q*lsw_pkg::EVT_W +: lsw_pkg::EVT_W];

  // Clear only on completion outcome, after the snapshot was streamed
  always_comb begin
    clr_vec = '0;
    if (state_q == LSW_WAIT && rd_ok && !retain_q) begin
      clr_vec[sel_q] = 1'b1; // see [R07] see [R08] see [R10]
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= LSW_IDLE;
    end else begin
      case (state_q)
        LSW_IDLE: begin
          if (rd_start) begin
            state_q <= LSW_SEND;
          end
        end
        LSW_SEND: begin
          if (idx_q == lsw_pkg::LAST_BYTE) begin
            state_q <= LSW_WAIT;
          end
        end
        LSW_WAIT: begin
          state_q <= LSW_IDLE; // see [R10]
        end
        default: begin
          state_q <= LSW_IDLE;
        end
      endcase
    end
  end

  // Capture set and retain bit at command start
  always_ff @(posedge mclk) begin
    if (srst) begin
      sel_q <= '0;
      retain_q <= 1'b0;
    end else if (state_q == LSW_IDLE && rd_start) begin
      sel_q <= cdw11[lsw_pkg::SET_W-1:0]; // see [R02]
      retain_q <= retain_evt;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      idx_q <= '0;
    end else if (state_q == LSW_SEND) begin
      idx_q <= idx_q + 9'h001; // see [R01]
    end else begin
      idx_q <= '0;
    end
  end

  always_comb begin
    byte_d = 8'h00; // see [R04]
    if (idx_q == lsw_pkg::OFF_STATUS) begin
      byte_d = {5'h00, sel_win}; // see [R03] see [R04]
    end else if (idx_q == lsw_pkg::OFF_EVT_LO) begin
      byte_d = {5'h00, sel_flags}; // see [R05]
    end else if (idx_q >= lsw_pkg::OFF_TYP_LO &&
                 idx_q <= lsw_pkg::OFF_TYP_HI) begin
      byte_d = lsw_pkg::TYP_FILL; // see [R09]
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
      byte_index <= 9'h000;
      byte_last <= 1'b0;
    end else begin
      byte_valid <= (state_q == LSW_SEND);
      byte_data <= (state_q == LSW_SEND) ? byte_d : 8'h00;
      byte_index <= idx_q;
      byte_last <= (state_q == LSW_SEND) && (idx_q == lsw_pkg::LAST_BYTE);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      async_q <= 1'b0;
    end else begin
      async_q <= |new_vec; // see [R11]
    end
  end

  assign async_evt = async_q;
  assign rd_busy = (state_q != LSW_IDLE);
  assign rd_done = (state_q == LSW_WAIT);

  // Counts streamed bytes so the length check needs no long delay
  logic [9:0] vcnt_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      vcnt_q <= '0;
    end else if (state_q == LSW_IDLE && rd_start) begin
      vcnt_q <= '0;
    end else if (byte_valid) begin
      vcnt_q <= vcnt_q + 10'h001;
    end
  end

  sequence s_take;
    state_q == LSW_IDLE && rd_start;
  endsequence

  sequence s_first_byte;
    byte_valid && byte_index == lsw_pkg::OFF_STATUS;
  endsequence

  sequence s_clear_read;
    rd_done && rd_ok && !retain_q &&
    evt_in[sel_q*lsw_pkg::EVT_W +: lsw_pkg::EVT_W] == lsw_pkg::EVT_RESET;
  endsequence

  property p_start;
    @(posedge mclk) disable iff (srst)
      s_take |=> ##1 s_first_byte;
  endproperty
  a_start: assert property (p_start) // see [R01]
    else $error("record did not start");

  property p_len;
    @(posedge mclk) disable iff (srst)
      byte_last |-> byte_valid && byte_index == lsw_pkg::LAST_BYTE &&
        vcnt_q == {1'b0, lsw_pkg::LAST_BYTE};
  endproperty
  a_len: assert property (p_len) // see [R01]
    else $error("record not 512 bytes");

  property p_rsvd;
    @(posedge mclk) disable iff (srst)
      (byte_valid && byte_index != lsw_pkg::OFF_STATUS &&
       byte_index != lsw_pkg::OFF_EVT_LO &&
       (byte_index < lsw_pkg::OFF_TYP_LO || byte_index > lsw_pkg::OFF_TYP_HI))
      |-> byte_data == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) // see [R04]
    else $error("reserved byte nonzero");

  property p_win;
    @(posedge mclk) disable iff (srst)
      (byte_valid && byte_index == lsw_pkg::OFF_STATUS)
      |-> byte_data[7:3] == 5'h00 && byte_data[2:0] != 3'h3 &&
          byte_data[2] == 1'b0;
  endproperty
  a_win: assert property (p_win) else $error("bad window code"); // see [R03]

  property p_evt;
    @(posedge mclk) disable iff (srst)
      (byte_valid && byte_index == lsw_pkg::OFF_EVT_LO)
      |-> byte_data == {5'h00, $past(sel_flags)};
  endproperty
  a_evt: assert property (p_evt) // see [R05]
    else $error("event byte mismatch");

  property p_clr;
    @(posedge mclk) disable iff (srst)
      s_clear_read
      |=> sel_flags == 3'h0 && agg_entries[$past(sel_q)] == 1'b0;
  endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared"); // see [R07]

  property p_keep;
    @(posedge mclk) disable iff (srst)
      (rd_done && (retain_q || !rd_ok)) |=> $past(sel_flags) == 3'h0 ||
      (sel_flags & $past(sel_flags)) == $past(sel_flags);
  endproperty
  a_keep: assert property (p_keep) else $error("flags lost"); // see [R10]

  property p_typ;
    @(posedge mclk) disable iff (srst)
      (byte_valid && byte_index >= lsw_pkg::OFF_TYP_LO &&
       byte_index <= lsw_pkg::OFF_TYP_HI) |-> byte_data == lsw_pkg::TYP_FILL;
  endproperty
  a_typ: assert property (p_typ) // see [R09]
    else $error("typical byte changed");

  property p_async;
    @(posedge mclk) disable iff (srst)
      (|(agg_entries & ~$past(agg_entries))) |-> async_evt;
  endproperty
  a_async: assert property (p_async) // see [R11]
    else $error("no async event");

  property p_sel;
    @(posedge mclk) disable iff (srst)
      (state_q == LSW_IDLE && rd_start)
      |=> sel_q == $past(cdw11[lsw_pkg::SET_W-1:0]);
  endproperty
  a_sel: assert property (p_sel) else $error("set not captured"); // see [R02]

  property p_run;
    @(posedge mclk) disable iff (srst)
      (byte_valid && !byte_last)
      |=> byte_valid && byte_index == $past(byte_index) + 9'h001;
  endproperty
  a_run: assert property (p_run) // see [R01]
    else $error("record stream broken");

  property p_done;
    @(posedge mclk) disable iff (srst)
      byte_last |-> rd_done;
  endproperty
  a_done: assert property (p_done) // see [R01]
    else $error("done missing at last byte");

  property p_idle;
    @(posedge mclk) disable iff (srst)
      rd_done |=> !rd_busy;
  endproperty
  a_idle: assert property (p_idle) // see [R01]
    else $error("busy after done");

  // Without a clear no flag may drop
  property p_sticky;
    @(posedge mclk) disable iff (srst)
      (clr_vec == '0) |=> (flag_vec & $past(flag_vec)) == $past(flag_vec);
  endproperty
  a_sticky: assert property (p_sticky) // see [R06]
    else $error("event flag dropped");

  // An event always lands, even in the clear cycle
  property p_evt_set;
    @(posedge mclk) disable iff (srst)
      (|evt_in) |=> (flag_vec & $past(evt_in)) == $past(evt_in);
  endproperty
  a_evt_set: assert property (p_evt_set) // see [R06]
    else $error("event not recorded");

  property p_keep_agg;
    @(posedge mclk) disable iff (srst)
      (rd_done && (retain_q || !rd_ok) && agg_entries[sel_q])
      |=> agg_entries[sel_q];
  endproperty
  a_keep_agg: assert property (p_keep_agg) // see [R10]
    else $error("aggregate entry lost");

  property p_fold;
    @(posedge mclk) disable iff (srst)
      sel_win == lsw_pkg::WIN_OFF || sel_win == lsw_pkg::WIN_DET ||
      sel_win == lsw_pkg::WIN_NDET;
  endproperty
  a_fold: assert property (p_fold) // see [R03]
    else $error("reserved window code");
endmodule // lsw_log_top

// ---- lsw_log_top_tb_top.sv ----
// Self-checking bench for the per-set latency window log block
`timescale 1ns/1ps
module lsw_log_top_tb_top;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [47:0] set_window = 48'h0;
  logic [47:0] evt_in = 48'h0;
  logic rd_start, retain_evt, rd_ok, rd_busy, byte_valid, rd_done, async_evt;
  logic [31:0] cdw11;
  logic [7:0] byte_data;
  logic [8:0] byte_index;
  logic [15:0] agg_entries;
  int mismatches = 0;
  int num_checks = 0;
  int n_async = 0;
  int n_last = 0;
  logic byte_last;
  always #5 mclk = ~mclk;
  lsw_log_top DUT (.mclk(mclk), .srst(srst), .rd_start(rd_start),
    .cdw11(cdw11), .retain_evt(retain_evt), .rd_ok(rd_ok),
    .set_window(set_window), .evt_in(evt_in), .rd_busy(rd_busy),
    .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_index(byte_index), .byte_last(byte_last), .rd_done(rd_done),
    .agg_entries(agg_entries), .async_evt(async_evt));
  lsw_host_model host (.mclk(mclk), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_index(byte_index), .rd_done(rd_done),
    .rd_start(rd_start), .cdw11(cdw11), .retain_evt(retain_evt),
    .rd_ok(rd_ok));
  always @(negedge mclk) if (async_evt === 1'b1) n_async++;
  always @(negedge mclk) if (byte_last === 1'b1) n_last++;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic check_rec(input logic [7:0] win, input logic [7:0] evt);
    logic [7:0] e;
    check(16'(host.n_bytes), 16'h0200);
    for (int i = 0; i < 512; i++) begin
      e = (i >= 32 && i <= 71) ? 8'hff : 8'h00;
      if (i == 0) e = win;
      if (i == 2) e = evt;
      check({8'h0, host.rec[i]}, {8'h0, e});
    end
  endtask
  task automatic s_reset();
    check({13'h0, rd_busy, byte_valid, byte_last}, 16'h0000);
    check({15'h0, async_evt}, 16'h0000);
    check(agg_entries, 16'h0000);
  endtask
  task automatic s_window();
    for (int c = 0; c < 8; c++) begin
      @(posedge mclk);
      set_window[15 +: 3] <= 3'(c);
      set_window[18 +: 3] <= 3'(~c);
      repeat (5) @(posedge mclk);
      host.read(4'h5, 1'b1, 1'b1);
      check_rec(8'((c == 1 || c == 2) ? c : 0), 8'h00);
    end
  endtask
  task automatic pulse(input int set, input int b);
    @(posedge mclk);
    evt_in[set*3+b] <= 1'b1;
    @(posedge mclk);
    evt_in[set*3+b] <= 1'b0;
  endtask
  task automatic s_events();
    int a0;
    a0 = n_async;
    pulse(3, 0);
    pulse(3, 2);
    pulse(9, 1);
    repeat (3) @(posedge mclk);
    check(agg_entries, 16'h0208);
    check(16'(n_async - a0), 16'h0002);
    host.read(4'h3, 1'b1, 1'b1);
    check_rec(8'h00, 8'h05);
    host.read(4'h3, 1'b0, 1'b0);
    check_rec(8'h00, 8'h05);
    // Look after the completion edge has settled
    @(negedge mclk);
    check(agg_entries, 16'h0208);
    host.read(4'h3, 1'b0, 1'b1);
    check_rec(8'h00, 8'h05);
    @(negedge mclk);
    check(agg_entries, 16'h0200);
    host.read(4'h3, 1'b1, 1'b1);
    check_rec(8'h00, 8'h00);
    host.read(4'h9, 1'b1, 1'b1);
    check_rec(8'h00, 8'h02);
    check(16'(n_last), 16'h000d);
  endtask
  task automatic final_report();
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    s_reset();
    s_window();
    s_events();
    final_report();
  end
  // Thirteen reads of about 520 cycles each fit well inside this span
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
endmodule // lsw_log_top_tb_top

// ---- lsw_pkg.sv ----
// Package of constants for the per-set latency window log block
package lsw_pkg;
  localparam int SET_W = 4;
  localparam int NUM_SETS = 16;
  localparam int LOG_BYTES = 512;
  localparam logic [8:0] LAST_BYTE = 9'h1ff;
  localparam logic [8:0] OFF_STATUS = 9'h000;
  localparam logic [8:0] OFF_RSVD1 = 9'h001;
  localparam logic [8:0] OFF_EVT_LO = 9'h002;
  localparam logic [8:0] OFF_EVT_HI = 9'h003;
  localparam logic [8:0] OFF_TYP_LO = 9'h020;
  localparam logic [8:0] OFF_TYP_HI = 9'h047;
  localparam int EVT_READS = 0;
  localparam int EVT_WRITES = 1;
  localparam int EVT_TIME = 2;
  localparam int EVT_W = 3;
  localparam logic [2:0] WIN_OFF = 3'h0;
  localparam logic [2:0] WIN_DET = 3'h1;
  localparam logic [2:0] WIN_NDET = 3'h2;
  localparam logic [7:0] TYP_FILL = 8'hff;
  localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;
endpackage

// ---- lsw_set_flags.sv ----
// Sticky event flags and aggregate entry of one storage set
`timescale 1ns/1ps
module lsw_set_flags (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [lsw_pkg::EVT_W-1:0] evt_set,
  input wire logic clr,
  output logic [lsw_pkg::EVT_W-1:0] flags_q,
  output logic agg_q,
  output logic agg_new
);
  logic [lsw_pkg::EVT_W-1:0] flags_d;
  logic agg_d;

  // Set beats clear so an event in the clear cycle survives
  always_comb begin
    flags_d = (clr ? lsw_pkg::EVT_RESET : flags_q) | evt_set; // see [R06]
    agg_d = (clr ? 1'b0 : agg_q) | (|evt_set); // see [R08]
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      flags_q <= lsw_pkg::EVT_RESET;
    end else begin
      flags_q <= flags_d; // see [R07]
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      agg_q <= 1'b0;
    end else begin
      agg_q <= agg_d;
    end
  end

  assign agg_new = agg_d & ~agg_q; // see [R11]
endmodule // lsw_set_flags

// ---- lsw_win_sync.sv ----
// Three-stage synchroniser for the window code inputs of one set
`timescale 1ns/1ps
module lsw_win_sync (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [2:0] win_in,
  output logic [2:0] win_q
);
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      s1_q <= lsw_pkg::WIN_OFF;
      s2_q <= lsw_pkg::WIN_OFF;
      s3_q <= lsw_pkg::WIN_OFF;
    end else begin
      s1_q <= win_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept only once two stages agree; undefined codes fold to off
  always_ff @(posedge mclk) begin
    if (srst) begin
      win_q <= lsw_pkg::WIN_OFF;
    end else if (s2_q == s3_q) begin
      if (s3_q == lsw_pkg::WIN_DET || s3_q == lsw_pkg::WIN_NDET) begin
        win_q <= s3_q; // see [R03]
      end else begin
        win_q <= lsw_pkg::WIN_OFF; // see [R03]
      end
    end
  end
endmodule // lsw_win_sync
